// ===== logic/eprom_eeprom_pkg.sv
// constants, field layouts and carrier types for the programming control
// Overview of operation
// - option-map bit on maps option byte at 3c00, else boot rom byte
// - option byte reachable only while option-map bit is set, any mode
// - with otp latch set, writes to otp array capture address and data
// - otp array reads return nothing while otp latch is set
// - otp power settable only with latch already set; cleared whenever latch low
// - one write cannot set otp latch and otp power together
// - unimplemented option bits read zero; erased option byte loads zero at reset
// - all options disabled while option byte is being programmed
// - low-voltage reset enable bit; stop disabled makes stop instruction reset chip
// - interrupt level bit adds level sensing; watchdog bit is a disable
// - any reset aborts an eeprom write at once
// - pump enable runs charge pump; voltage delivered only with ee power
// - two-bit erase field: none, byte, block, bulk; cleared by reset
// - byte erases one byte, block the aligned 64 bytes holding the written byte, bulk 256 bytes
// - ee latch captures array writes; array reads blocked after such a write
// - rc select moves eeprom to rc clock; software waits settle time
// - ee power readable always, writable only with ee latch set
// - eeprom rc oscillator off in stop; software turns it off for wait
`default_nettype none
package eprom_eeprom_pkg;
    ////////////////////////////////////////////////////////////////////////
    localparam logic [15:0] OTP_CTRL_ADDR = 16'h000d;
    localparam logic [15:0] EE_CTRL_ADDR  = 16'h001c;
    localparam logic [15:0] STATUS_ADDR   = 16'h001d;
    localparam logic [15:0] OPT_ADDR      = 16'h3c00;
    localparam logic [15:0] EE_BASE       = 16'h0240;
    localparam logic [15:0] EE_LAST       = 16'h033f;
    localparam logic [15:0] OTP_FIRST_DEF = 16'h1000;
    localparam logic [15:0] OTP_LAST_DEF  = 16'h3bff;
    ////////////////////////////////////////////////////////////////////////
    localparam int OTP_POWER_BIT = 0;
    localparam int OTP_LATCH_BIT = 1;
    localparam int OPT_MAP_BIT   = 2;
    localparam int EE_POWER_BIT  = 0;
    localparam int EE_RC_BIT     = 1;
    localparam int EE_LATCH_BIT  = 2;
    localparam int ERASE_LO_BIT  = 3;
    localparam int ERASE_HI_BIT  = 4;
    localparam int PUMP_BIT      = 5;
    localparam int ST_OTP_CAP    = 0;
    localparam int ST_EE_WR      = 1;
    localparam int ST_OTP_DONE   = 2;
    localparam int ST_EE_DONE    = 3;
    localparam int OPT_WD_DIS    = 0;
    localparam int OPT_IRQ_LVL   = 1;
    localparam int OPT_STOP_EN   = 2;
    localparam int OPT_LVR_EN    = 3;
    localparam logic [7:0] OPT_IMPL_MASK = 8'h0f;
    localparam logic [7:0] EE_BLOCK_MASK = 8'hc0;
    localparam logic [7:0] EE_LAST_OFF   = 8'hff;
    localparam logic [7:0] BYTE_ZERO     = 8'h00;
    localparam logic [7:0] BLOCK_SPAN    = 8'h3f;
    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        ERASE_NONE  = 2'h0,
        ERASE_BYTE  = 2'h1,
        ERASE_BLOCK = 2'h2,
        ERASE_BULK  = 2'h3
    } erase_e;

    typedef struct packed {
        logic [7:0] first;
        logic [7:0] last;
        logic [7:0] data;
        erase_e     mode;
        logic       hv_on;
        logic       pump_on;
        logic       rc_clk_sel;
        logic       rc_osc_en;
    } ee_prog_s;

    typedef struct packed {
        logic low_volt_reset_en;
        logic stop_instr_en;
        logic irq_level_sens;
        logic watchdog_en;
    } opt_set_s;
endpackage
`default_nettype wire

// ===== logic/pulse_timer.sv
// cycle counter that flags when a power pulse has lasted its set length
`default_nettype none
module pulse_timer #(
    parameter int TW = 24
) (
    input  wire logic          clock,
    input  wire logic          rst,
    input  wire logic          run,
    input  wire logic [TW-1:0] limit,
    output logic               done
);
    typedef struct packed {
        logic [TW-1:0] count;
        logic          done;
    } tmr_s;

    tmr_s s_r;
    tmr_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        // restarting on every drop keeps each pulse timed on its own
        if (!run) begin
            s_nxt.count = '0;
            s_nxt.done  = 1'b0;
        end else if (s_r.count >= limit) begin
            s_nxt.done = 1'b1;
        end else begin
            s_nxt.count = s_r.count + 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign done = s_r.done;
endmodule
`default_nettype wire

// ===== logic/eprom_eeprom_program_control.sv
// otp, option byte and eeprom programming control with cpu register port
`default_nettype none
module eprom_eeprom_program_control
    import eprom_eeprom_pkg::*;
#(
    parameter logic [15:0] OTP_FIRST       = OTP_FIRST_DEF,
    parameter logic [15:0] OTP_LAST        = OTP_LAST_DEF,
    parameter int          TW              = 24,
    parameter int          OTP_PULSE_CYC   = 800000,
    parameter int          EE_PROG_CYC     = 2000000,
    parameter int          BYTE_ERASE_CYC  = 2000000,
    parameter int          BLOCK_ERASE_CYC = 2000000,
    parameter int          BULK_ERASE_CYC  = 2000000
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [15:0] addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [7:0]  rdata,
    input  wire logic [7:0]  otp_rdata,
    input  wire logic [7:0]  ee_rdata,
    input  wire logic [7:0]  boot_rdata,
    input  wire logic [7:0]  opt_cell,
    input  wire logic        stop_exec,
    input  wire logic        stop_mode,
    output logic      [15:0] otp_prog_addr,
    output logic      [7:0]  otp_prog_data,
    output logic             otp_vpp_on,
    output ee_prog_s         ee_prog,
    output opt_set_s         options,
    output logic             stop_enter,
    output logic             stop_reset_req
);
    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic        otp_power;
        logic        otp_latch;
        logic        opt_map;
        logic        pump_en;
        erase_e      erase_sel;
        logic        ee_latch;
        logic        rc_sel;
        logic        ee_power;
        logic [15:0] otp_cap_addr;
        logic [7:0]  otp_cap_data;
        logic        otp_captured;
        logic [7:0]  ee_cap_off;
        logic        ee_written;
        logic        opt_loaded;
        logic [7:0]  opt_val;
        logic [7:0]  rdata;
        logic        otp_vpp;
        ee_prog_s    ee;
        opt_set_s    opt;
        logic        stop_enter;
        logic        stop_reset;
    } state_s;

    localparam state_s STATE_RESET = '0;

    state_s      s_r;
    state_s      s_nxt;
    logic        hit_otp;
    logic        hit_ee;
    logic        hit_opt;
    logic [15:0] ee_diff;
    logic        opt_off;
    logic        otp_done;
    logic        ee_done;
    logic [TW-1:0] ee_limit;
    logic [7:0]  otp_ctrl_rd;
    logic [7:0]  ee_ctrl_rd;
    logic [7:0]  status_rd;

    ////////////////////////////////////////////////////////////////////////
    // pulse length timers, readable through the status register
    pulse_timer #(.TW(TW)) u_otp_timer (
        .clock (clock),
        .rst   (rst),
        .run   (s_r.otp_power),
        .limit (TW'(OTP_PULSE_CYC)),
        .done  (otp_done)
    );

    always_comb begin
        unique case (s_r.erase_sel)
            ERASE_NONE:  ee_limit = TW'(EE_PROG_CYC);
            ERASE_BYTE:  ee_limit = TW'(BYTE_ERASE_CYC);
            ERASE_BLOCK: ee_limit = TW'(BLOCK_ERASE_CYC);
            ERASE_BULK:  ee_limit = TW'(BULK_ERASE_CYC);
        endcase
    end

    pulse_timer #(.TW(TW)) u_ee_timer (
        .clock (clock),
        .rst   (rst),
        .run   (s_r.ee_power),
        .limit (ee_limit),
        .done  (ee_done)
    );

    ////////////////////////////////////////////////////////////////////////
    assign hit_otp = (addr >= OTP_FIRST) && (addr <= OTP_LAST);
    assign hit_ee  = (addr >= EE_BASE) && (addr <= EE_LAST);
    assign hit_opt = (addr == OPT_ADDR);
    assign ee_diff = addr - EE_BASE;

    always_comb begin
        otp_ctrl_rd = BYTE_ZERO;
        otp_ctrl_rd[OTP_POWER_BIT] = s_r.otp_power;
        otp_ctrl_rd[OTP_LATCH_BIT] = s_r.otp_latch;
        otp_ctrl_rd[OPT_MAP_BIT]   = s_r.opt_map;
        ee_ctrl_rd = BYTE_ZERO;
        ee_ctrl_rd[EE_POWER_BIT] = s_r.ee_power;
        ee_ctrl_rd[EE_RC_BIT]    = s_r.rc_sel;
        ee_ctrl_rd[EE_LATCH_BIT] = s_r.ee_latch;
        ee_ctrl_rd[ERASE_HI_BIT:ERASE_LO_BIT] = s_r.erase_sel;
        ee_ctrl_rd[PUMP_BIT]     = s_r.pump_en;
        status_rd = BYTE_ZERO;
        status_rd[ST_OTP_CAP]  = s_r.otp_captured;
        status_rd[ST_EE_WR]    = s_r.ee_written;
        status_rd[ST_OTP_DONE] = otp_done;
        status_rd[ST_EE_DONE]  = ee_done;
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_nxt = s_r;
        // control register writes
        if (wr && addr == OTP_CTRL_ADDR) begin
            s_nxt.otp_latch = wdata[OTP_LATCH_BIT];
            s_nxt.opt_map   = wdata[OPT_MAP_BIT];
            // old latch must already be set, so latch and power in one
            // write never raises the power
            s_nxt.otp_power = wdata[OTP_POWER_BIT] && s_r.otp_latch;
        end
        if (!s_nxt.otp_latch) begin
            s_nxt.otp_power    = 1'b0;
            s_nxt.otp_captured = 1'b0;
        end
        if (wr && addr == EE_CTRL_ADDR) begin
            s_nxt.pump_en   = wdata[PUMP_BIT];
            s_nxt.erase_sel = erase_e'(wdata[ERASE_HI_BIT:ERASE_LO_BIT]);
            s_nxt.ee_latch  = wdata[EE_LATCH_BIT];
            s_nxt.rc_sel    = wdata[EE_RC_BIT];
            if (s_r.ee_latch) begin
                s_nxt.ee_power = wdata[EE_POWER_BIT];
            end
        end
        if (!s_nxt.ee_latch) begin
            s_nxt.ee_written = 1'b0;
        end

        // array writes are captured for programming
        if (wr && s_r.otp_latch && (hit_otp || (hit_opt && s_r.opt_map))) begin
            s_nxt.otp_cap_addr = addr;
            s_nxt.otp_cap_data = wdata;
            s_nxt.otp_captured = 1'b1;
        end
        if (wr && hit_ee && s_r.ee_latch) begin
            s_nxt.ee_cap_off  = ee_diff[7:0];
            s_nxt.ee.data     = wdata;
            s_nxt.ee_written  = 1'b1;
        end

        // read data stands for exactly the cycle after the strobe
        s_nxt.rdata = BYTE_ZERO;
        if (rd) begin
            if (addr == OTP_CTRL_ADDR) begin
                s_nxt.rdata = otp_ctrl_rd;
            end else if (addr == EE_CTRL_ADDR) begin
                s_nxt.rdata = ee_ctrl_rd;
            end else if (addr == STATUS_ADDR) begin
                s_nxt.rdata = status_rd;
            end else if (hit_opt) begin
                s_nxt.rdata = s_r.opt_map ? (opt_cell & OPT_IMPL_MASK)
                                          : boot_rdata;
            end else if (hit_otp) begin
                s_nxt.rdata = s_r.otp_latch ? BYTE_ZERO : otp_rdata;
            end else if (hit_ee) begin
                s_nxt.rdata = (s_r.ee_latch && s_r.ee_written) ? BYTE_ZERO
                                                               : ee_rdata;
            end
        end

        // option cell copied once, on the first edge after reset release
        if (!s_r.opt_loaded) begin
            s_nxt.opt_loaded = 1'b1;
            s_nxt.opt_val    = opt_cell & OPT_IMPL_MASK;
        end
        opt_off = s_nxt.opt_map && s_nxt.otp_latch && s_nxt.otp_power;
        s_nxt.opt.low_volt_reset_en = !opt_off && s_nxt.opt_loaded
                                      && s_nxt.opt_val[OPT_LVR_EN];
        s_nxt.opt.stop_instr_en     = !opt_off && s_nxt.opt_loaded
                                      && s_nxt.opt_val[OPT_STOP_EN];
        s_nxt.opt.irq_level_sens    = !opt_off && s_nxt.opt_loaded
                                      && s_nxt.opt_val[OPT_IRQ_LVL];
        s_nxt.opt.watchdog_en       = !opt_off && s_nxt.opt_loaded
                                      && !s_nxt.opt_val[OPT_WD_DIS];
        s_nxt.stop_enter = stop_exec && s_r.opt.stop_instr_en;
        s_nxt.stop_reset = stop_exec && !s_r.opt.stop_instr_en;

        // power and erase outputs
        s_nxt.otp_vpp    = s_nxt.otp_power;
        s_nxt.ee.hv_on   = s_nxt.ee_power;
        s_nxt.ee.pump_on = s_nxt.pump_en || s_nxt.ee_power;
        s_nxt.ee.rc_clk_sel = s_nxt.rc_sel;
        s_nxt.ee.rc_osc_en  = s_nxt.rc_sel && !stop_mode;
        s_nxt.ee.mode    = s_nxt.erase_sel;
        unique case (s_nxt.erase_sel)
            ERASE_BLOCK: begin
                s_nxt.ee.first = s_nxt.ee_cap_off & EE_BLOCK_MASK;
                s_nxt.ee.last  = s_nxt.ee_cap_off | BLOCK_SPAN;
            end
            ERASE_BULK: begin
                s_nxt.ee.first = BYTE_ZERO;
                s_nxt.ee.last  = EE_LAST_OFF;
            end
            ERASE_NONE, ERASE_BYTE: begin
                s_nxt.ee.first = s_nxt.ee_cap_off;
                s_nxt.ee.last  = s_nxt.ee_cap_off;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // reset drops every power output at once, abandoning any write
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_r <= STATE_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata          = s_r.rdata;
    assign otp_prog_addr  = s_r.otp_cap_addr;
    assign otp_prog_data  = s_r.otp_cap_data;
    assign otp_vpp_on     = s_r.otp_vpp;
    assign ee_prog        = s_r.ee;
    assign options        = s_r.opt;
    assign stop_enter     = s_r.stop_enter;
    assign stop_reset_req = s_r.stop_reset;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence otp_latch_write;
        wr && addr == OTP_CTRL_ADDR && wdata[OTP_LATCH_BIT]
        && !wdata[OTP_POWER_BIT];
    endsequence

    sequence otp_power_write;
        wr && addr == OTP_CTRL_ADDR && wdata[OTP_LATCH_BIT]
        && wdata[OTP_POWER_BIT];
    endsequence

    power_follows_latch_a: assert property (
        s_r.otp_latch ##0 otp_power_write |=> s_r.otp_power && otp_vpp_on)
        else $error("otp power not raised after latch then power write");

    latch_write_a: assert property (
        otp_latch_write |=> s_r.otp_latch && !s_r.otp_power)
        else $error("latch write raised otp power");

    power_auto_clear_a: assert property (
        !s_r.otp_latch |-> !otp_vpp_on)
        else $error("otp power on with latch clear");

    power_needs_latch_a: assert property (
        s_r.otp_power |-> s_r.otp_latch)
        else $error("otp power set without latch");

    single_write_a: assert property (
        !s_r.otp_latch ##0 otp_power_write |=> !s_r.otp_power ##1 !otp_vpp_on)
        else $error("latch and power accepted in one write");

    otp_read_block_a: assert property (
        rd && hit_otp && s_r.otp_latch |=> rdata == BYTE_ZERO)
        else $error("otp data returned while latched");

    opt_map_read_a: assert property (
        rd && hit_opt |=> rdata == ($past(s_r.opt_map)
            ? ($past(opt_cell) & OPT_IMPL_MASK) : $past(boot_rdata)))
        else $error("option location read wrong source");

    otp_capture_a: assert property (
        wr && hit_otp && s_r.otp_latch |=> otp_prog_addr == $past(addr)
            && otp_prog_data == $past(wdata))
        else $error("otp write not captured");

    options_off_a: assert property (
        s_r.opt_map && s_r.otp_latch && s_r.otp_power |-> options == '0)
        else $error("option active while option byte programmed");

    watchdog_sense_a: assert property (
        s_r.opt_loaded && !s_r.otp_power |-> options.watchdog_en
            == !s_r.opt_val[OPT_WD_DIS])
        else $error("watchdog enable not inverse of disable bit");

    stop_reset_a: assert property (
        stop_exec && !options.stop_instr_en |=> stop_reset_req && !stop_enter)
        else $error("stop without enable did not request reset");

    ee_power_write_a: assert property (
        wr && addr == EE_CTRL_ADDR && !s_r.ee_latch && !s_r.ee_power
        |=> !s_r.ee_power ##1 !ee_prog.hv_on)
        else $error("ee power set without ee latch");

    ee_read_block_a: assert property (
        rd && hit_ee && s_r.ee_latch && s_r.ee_written |=> rdata == BYTE_ZERO)
        else $error("eeprom data returned after latched write");

    block_range_a: assert property (
        ee_prog.mode == ERASE_BLOCK |-> (ee_prog.first & BLOCK_SPAN) == BYTE_ZERO
            && ee_prog.last == (ee_prog.first | BLOCK_SPAN))
        else $error("block erase range not a 64 byte block");

    rc_stop_a: assert property (
        stop_mode |=> !ee_prog.rc_osc_en)
        else $error("eeprom rc oscillator running in stop");

    pump_follow_a: assert property (
        ee_prog.hv_on |-> ee_prog.pump_on)
        else $error("programming voltage without pump");

    opt_write_refused_a: assert property (
        wr && hit_opt && !s_r.opt_map |=> $stable(otp_prog_addr))
        else $error("option write captured without map bit");

    ee_capture_a: assert property (
        wr && hit_ee && s_r.ee_latch |=> ee_prog.data == $past(wdata))
        else $error("eeprom write data not captured");

    erase_field_a: assert property (
        wr && addr == EE_CTRL_ADDR
        |=> ee_prog.mode == $past(wdata[ERASE_HI_BIT:ERASE_LO_BIT]))
        else $error("erase field not taken from write");

    rc_select_a: assert property (
        wr && addr == EE_CTRL_ADDR
        |=> ee_prog.rc_clk_sel == $past(wdata[EE_RC_BIT]))
        else $error("rc clock select not taken from write");
endmodule
`default_nettype wire

// ===== sim/tb_eprom_eeprom_program_control.sv
// self-checking bench for the otp, option byte and eeprom programming control
`default_nettype none
module tb_eprom_eeprom_program_control
    import eprom_eeprom_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////////
    logic        clock;
    logic        rst;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic [7:0]  otp_rdata;
    logic [7:0]  ee_rdata;
    logic [7:0]  boot_rdata;
    logic [7:0]  opt_cell;
    logic        stop_exec;
    logic        stop_mode;
    logic [15:0] otp_prog_addr;
    logic [7:0]  otp_prog_data;
    logic        otp_vpp_on;
    ee_prog_s    ee_prog;
    opt_set_s    options;
    logic        stop_enter;
    logic        stop_reset_req;
    int          mismatches;
    int          comparisons;
    logic [7:0]  v;
    ////////////////////////////////////////////////////////////////////////
    // short durations keep the run small; pulse status comes 11 cycles after power rises
    eprom_eeprom_program_control #(
        .OTP_PULSE_CYC(10), .EE_PROG_CYC(10),
        .BYTE_ERASE_CYC(10), .BLOCK_ERASE_CYC(10), .BULK_ERASE_CYC(10)
    ) u_dut (
        .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .otp_rdata(otp_rdata),
        .ee_rdata(ee_rdata), .boot_rdata(boot_rdata),
        .opt_cell(opt_cell), .stop_exec(stop_exec),
        .stop_mode(stop_mode), .otp_prog_addr(otp_prog_addr),
        .otp_prog_data(otp_prog_data), .otp_vpp_on(otp_vpp_on),
        .ee_prog(ee_prog), .options(options), .stop_enter(stop_enter),
        .stop_reset_req(stop_reset_req)
    );
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h expected %h",
                     $time, what, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clock);
        wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
        @(posedge clock);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic pulse_stop();
        @(posedge clock);
        stop_exec <= 1'b1;
        @(posedge clock);
        stop_exec <= 1'b0;
        #1;
    endtask

    // a hang must not outlive the run budget
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        report_and_stop();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1; addr = 16'h0000; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
        otp_rdata = 8'h3c; ee_rdata = 8'h99; boot_rdata = 8'h81;
        opt_cell = 8'hfa; stop_exec = 1'b0; stop_mode = 1'b0;
        mismatches = 0; comparisons = 0;
        idle(12);
        rst <= 1'b0;
        idle(3);
        // reset values and option decode
        rd_reg(EE_CTRL_ADDR, v);
        chk(v, 16'h0000, "ee ctrl reset");
        rd_reg(16'h0050, v);
        chk(v, 16'h0000, "unmapped read");
        chk(options, 16'h000b, "options decode");
        pulse_stop();
        chk(stop_reset_req, 16'h0001, "stop disabled");
        $display("test reset_and_options done");
        // otp latch, capture, power ordering
        wr_reg(OTP_CTRL_ADDR, 8'h01);
        rd_reg(OTP_CTRL_ADDR, v);
        chk(v, 16'h0000, "power without latch");
        wr_reg(OTP_CTRL_ADDR, 8'h03);
        rd_reg(OTP_CTRL_ADDR, v);
        chk(v, 16'h0002, "latch and power together");
        wr_reg(16'h1000, 8'ha5);
        idle(2);
        chk(otp_prog_addr, 16'h1000, "otp capture addr");
        chk(otp_prog_data, 16'h00a5, "otp capture data");
        rd_reg(16'h1000, v);
        chk(v, 16'h0000, "otp read while latched");
        wr_reg(OTP_CTRL_ADDR, 8'h03);
        idle(2);
        chk(otp_vpp_on, 16'h0001, "otp power on");
        idle(12);
        rd_reg(STATUS_ADDR, v);
        chk(v, 16'h0005, "otp pulse elapsed");
        wr_reg(OTP_CTRL_ADDR, 8'h00);
        idle(3);
        chk(otp_vpp_on, 16'h0000, "otp power cleared with latch");
        rd_reg(16'h1000, v);
        chk(v, 16'h003c, "otp read restored");
        $display("test otp_program done");
        // option byte mapping
        rd_reg(OPT_ADDR, v);
        chk(v, 16'h0081, "boot byte at option addr");
        wr_reg(OTP_CTRL_ADDR, 8'h02);
        wr_reg(OPT_ADDR, 8'h0c);
        idle(2);
        chk(otp_prog_addr, 16'h1000, "option write without map");
        wr_reg(OTP_CTRL_ADDR, 8'h04);
        rd_reg(OPT_ADDR, v);
        chk(v, 16'h000a, "option byte mapped");
        wr_reg(OTP_CTRL_ADDR, 8'h00);
        $display("test option_map done");
        // eeprom power gating and erase modes
        wr_reg(EE_CTRL_ADDR, 8'h01);
        rd_reg(EE_CTRL_ADDR, v);
        chk(v, 16'h0000, "ee power without latch");
        for (int m = 0; m < 4; m++) begin
            wr_reg(EE_CTRL_ADDR, 8'h24 | 8'(m << 3));
            wr_reg(16'h0285, 8'h5a);
            wr_reg(EE_CTRL_ADDR, 8'h25 | 8'(m << 3));
            idle(2);
            chk(16'(ee_prog.mode), 16'(m), "erase mode");
            case (m)
                0, 1: chk({ee_prog.first, ee_prog.last}, 16'h4545,
                          "byte range");
                2: chk({ee_prog.first, ee_prog.last}, 16'h407f,
                       "block range");
                default: chk({ee_prog.first, ee_prog.last}, 16'h00ff,
                             "bulk range");
            endcase
            chk({ee_prog.hv_on, ee_prog.pump_on}, 16'h0003,
                "ee power");
            rd_reg(16'h0285, v);
            chk(v, 16'h0000, "ee read inhibited");
            idle(8);
            rd_reg(STATUS_ADDR, v);
            chk(v, 16'h000a, "ee status");
            wr_reg(EE_CTRL_ADDR, 8'h24 | 8'(m << 3));
            idle(2);
            chk(ee_prog.hv_on, 16'h0000, "ee power off");
            wr_reg(EE_CTRL_ADDR, 8'h00);
        end
        chk(ee_prog.data, 16'h005a, "ee data captured");
        rd_reg(16'h0285, v);
        chk(v, 16'h0099, "ee read restored");
        $display("test ee_modes done");
        // rc clock and stop mode
        wr_reg(EE_CTRL_ADDR, 8'h02);
        idle(2);
        chk({ee_prog.rc_clk_sel, ee_prog.rc_osc_en}, 16'h0003,
            "rc selected");
        @(posedge clock);
        stop_mode <= 1'b1;
        idle(3);
        chk(ee_prog.rc_osc_en, 16'h0000, "rc off in stop");
        stop_mode <= 1'b0;
        wr_reg(EE_CTRL_ADDR, 8'h00);
        $display("test rc_stop done");
        // reset in the middle of an eeprom write
        opt_cell <= 8'hf4;
        wr_reg(EE_CTRL_ADDR, 8'h24);
        wr_reg(16'h0300, 8'h11);
        wr_reg(EE_CTRL_ADDR, 8'h25);
        idle(2);
        rst <= 1'b1;
        #1 chk(ee_prog.hv_on, 16'h0000, "reset aborts write");
        idle(2);
        rst <= 1'b0;
        idle(3);
        rd_reg(EE_CTRL_ADDR, v);
        chk(v, 16'h0000, "ee ctrl cleared");
        chk(options, 16'h0005, "options reloaded");
        pulse_stop();
        chk(stop_enter, 16'h0001, "stop enabled");
        $display("test mid_reset done");
        // options off while the option byte is programmed
        wr_reg(OTP_CTRL_ADDR, 8'h06);
        wr_reg(OPT_ADDR, 8'h0c);
        wr_reg(OTP_CTRL_ADDR, 8'h07);
        idle(2);
        chk(otp_prog_addr, 16'h3c00, "option capture");
        chk(options, 16'h0000, "options disabled");
        pulse_stop();
        chk(stop_reset_req, 16'h0001, "stop while disabled");
        wr_reg(OTP_CTRL_ADDR, 8'h00);
        idle(3);
        chk(options, 16'h0005, "options back");
        $display("test option_program done");
        report_and_stop();
    end
endmodule
`default_nettype wire
